// ---- ctrl_regfile_model.sv ----
// behavioural register file standing behind the indirect window
`timescale 1ns/1ps
`default_nettype none
module ctrl_regfile_model
(
    input  wire logic        i_clk,      // clock
    input  wire logic [7:0]  i_idx,      // selected index
    input  wire logic        i_wr,       // write strobe
    input  wire logic [31:0] i_wdata,    // write data
    output logic      [31:0] o_rdata,    // data of selected index
    output logic             o_readable, // selected index readable
    output logic             o_writable  // selected index writable
);
    logic [31:0] mem_reg [256];
    initial for (int k = 0; k < 256; k++) mem_reg[k] = 32'h0000_0000;
    // index 01 read-only, index 03 write-only
    assign o_readable = (i_idx != 8'h03);
    assign o_writable = (i_idx != 8'h01);
    assign o_rdata    = mem_reg[i_idx];
    always @(posedge i_clk)
        if (i_wr) mem_reg[i_idx] <= i_wdata;
endmodule : ctrl_regfile_model
`default_nettype wire

// ---- indirect_register_window.sv ----
// indirect selector and data window in front of the controller register file
// Functional notes
// - both registers mapped at base-configured memory address
// - full dword write loads the selector
// - window accesses go to selector low byte
// - only whole 32-bit accesses are accepted
// - 64-bit registers appear as separate indices
// - selected register's attributes gate window access
`timescale 1ns/1ps
`default_nettype none
module indirect_register_window
    import regwin_pkg::*;
(
    input  wire logic                          i_clk,          // 250 MHz clock
    input  wire logic                          i_sys_rst,      // sync reset, high
    input  wire logic [7:0]                    i_window_base,  // base config xy byte
    input  wire logic                          i_mem_rd,       // memory read request
    input  wire logic                          i_mem_wr,       // memory write request
    input  wire logic [regwin_pkg::ADDR_W-1:0] i_mem_addr,     // byte address
    input  wire logic [regwin_pkg::BE_W-1:0]   i_mem_be,       // byte enables
    input  wire logic [regwin_pkg::DATA_W-1:0] i_mem_wdata,    // write data
    output logic      [regwin_pkg::DATA_W-1:0] o_mem_rdata,    // read data
    output logic                               o_mem_ack,      // access done pulse
    output logic                               o_mem_err,      // refused access, with ack
    output logic      [regwin_pkg::IDX_W-1:0]  o_int_idx,      // selected internal index
    output logic                               o_int_rd,       // internal read strobe
    output logic                               o_int_wr,       // internal write strobe
    output logic      [regwin_pkg::DATA_W-1:0] o_int_wdata,    // internal write data
    input  wire logic [regwin_pkg::DATA_W-1:0] i_int_rdata,    // internal read data
    input  wire logic                          i_int_readable, // selected reg readable
    input  wire logic                          i_int_writable  // selected reg writable
);
    import regwin_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    win_state_e             state_reg;
    logic [IDX_W-1:0]       select_reg;
    logic                   hit;
    logic                   is_sel;
    logic                   is_win;
    logic                   full;
    logic                   req;
    logic                   rd_pend_reg;
    logic                   win_rd_reg;
    logic                   win_ok_reg;
    logic [DATA_W-1:0]      hold_data_next;

    // other offsets of the page are left to neighbouring decoders: no answer
    assign is_sel = (i_mem_addr[7:0] == OFF_SELECT);
    assign is_win = (i_mem_addr[7:0] == OFF_WINDOW);
    assign hit    = (i_mem_addr[31:16] == WIN_PAGE)
                 && (i_mem_addr[15:8] == i_window_base)
                 && (is_sel || is_win);
    assign full   = (i_mem_be == BE_FULL);
    assign req    = (state_reg == ST_IDLE) && (i_mem_rd || i_mem_wr) && hit;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing: take, issue, answer; one access in flight at a time
    // requests seen while busy are dropped, not queued; host waits for ack
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:  if (req) state_reg <= ST_ISSUE;
                ST_ISSUE: state_reg <= ST_DONE;
                ST_DONE:  state_reg <= ST_IDLE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selector register
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            select_reg <= SELECT_RESET[IDX_W-1:0];
        end
        else if (req && i_mem_wr && is_sel && full)
        begin
            // upper bits dropped: reserved
            select_reg <= i_mem_wdata[IDX_W-1:0];
        end
    end

    // index passes out unchanged; wide registers are just more indices
    assign o_int_idx = select_reg;

    ////////////////////////////////////////////////////////////////////////////
    // internal strobes
    // attributes are those of the index in force at the take edge
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_int_rd    <= 1'b0;
            o_int_wr    <= 1'b0;
            o_int_wdata <= WINDOW_RESET;
            win_rd_reg  <= 1'b0;
            win_ok_reg  <= 1'b0;
            rd_pend_reg <= 1'b0;
        end
        else
        begin
            o_int_rd <= req && i_mem_rd && is_win && full && i_int_readable;
            o_int_wr <= req && i_mem_wr && is_win && full && i_int_writable;
            if (req)
            begin
                o_int_wdata <= i_mem_wdata;
                win_rd_reg  <= i_mem_rd && is_win;
                rd_pend_reg <= i_mem_rd;
                win_ok_reg  <= full && (is_sel
                    || (i_mem_rd ? i_int_readable : i_int_writable));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer; a read of the selector returns only the index byte
    // refused and write accesses answer zero so stale data never leaks
    always_comb
    begin
        if (!rd_pend_reg || !win_ok_reg)
        begin
            hold_data_next = WINDOW_RESET;
        end
        else if (win_rd_reg)
        begin
            hold_data_next = i_int_rdata;
        end
        else
        begin
            hold_data_next = {{(DATA_W-IDX_W){1'b0}}, select_reg};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_mem_ack   <= 1'b0;
            o_mem_err   <= 1'b0;
            o_mem_rdata <= WINDOW_RESET;
        end
        else
        begin
            o_mem_ack   <= (state_reg == ST_ISSUE);
            o_mem_err   <= (state_reg == ST_ISSUE) && !win_ok_reg;
            o_mem_rdata <= (state_reg == ST_ISSUE) ? hold_data_next : WINDOW_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_MAP_ACK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        req |-> ##2 o_mem_ack)
        else $error("mapped access not answered two cycles later");

    AST_SEL_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && i_mem_wr && is_sel && full) |=> (select_reg == $past(i_mem_wdata[7:0])))
        else $error("selector did not capture written value");

    AST_WIN_IDX: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (o_int_rd || o_int_wr) |-> (o_int_idx == $past(select_reg)))
        else $error("window strobe with wrong index");

    AST_NARROW_REFUSED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && !full) |-> ##1 (!o_int_rd && !o_int_wr) ##1 o_mem_err)
        else $error("narrow access not refused");

    AST_IDX_INDEPENDENT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && is_win) |=> $stable(o_int_idx))
        else $error("window access changed the index");

    AST_WR_ATTR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && i_mem_wr && !i_mem_rd && is_win && !i_int_writable)
            |-> ##1 !o_int_wr ##1 o_mem_err)
        else $error("write to non-writable register passed");

    AST_SEL_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && i_mem_rd && is_sel && full) |-> ##2 (o_mem_rdata[31:8] == 24'h00_0000))
        else $error("selector upper bits read non-zero");

    // a read of a register without read access must not strobe the file
    AST_RD_ATTR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && i_mem_rd && is_win && !i_int_readable) |-> ##1 !o_int_rd ##1 o_mem_err)
        else $error("read of non-readable register passed");

    AST_WIN_RD_DATA: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (o_int_rd && (state_reg == ST_ISSUE)) |=> (o_mem_rdata == $past(i_int_rdata)))
        else $error("window read data not returned");

    AST_WIN_WR_DATA: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && i_mem_wr && is_win && full && i_int_writable)
            |=> (o_int_wr && (o_int_wdata == $past(i_mem_wdata))))
        else $error("window write not passed on");

    AST_NO_STROBE_ON_SEL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && is_sel) |=> (!o_int_rd && !o_int_wr))
        else $error("selector access strobed the register file");

    AST_NARROW_SEL_KEEPS: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (req && i_mem_wr && is_sel && !full) |=> $stable(select_reg))
        else $error("narrow selector write changed the index");

    AST_ERR_WITH_ACK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_mem_err |-> o_mem_ack)
        else $error("error flag without ack");

    AST_ERR_RDATA_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_mem_err |-> (o_mem_rdata == 32'h0000_0000))
        else $error("refused access returned data");

    AST_ACK_PULSE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_mem_ack |=> !o_mem_ack)
        else $error("ack held longer than one cycle");
endmodule : indirect_register_window
`default_nettype wire

// ---- indirect_register_window_tb.sv ----
// self-checking bench for the indirect register window
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module indirect_register_window_tb;
    import regwin_pkg::*;
    localparam logic [31:0] SEL = 32'hFEC0_2500;
    localparam logic [31:0] WIN = 32'hFEC0_2510;
    logic i_clk = 0, i_sys_rst = 1, i_mem_rd = 0, i_mem_wr = 0, rd_ok, wr_ok, o_mem_ack, e;
    logic o_mem_err, o_int_rd, o_int_wr;
    logic [3:0] i_mem_be = 4'hF;
    logic [7:0] o_int_idx;
    logic [7:0] i_window_base = 8'h25;
    logic [31:0] i_mem_addr = 0, i_mem_wdata = 0, o_mem_rdata, o_int_wdata, int_rdata, q;
    int n_tests = 0, num_errors = 0;
    int rd_seen = 0, wr_seen = 0;
    always #2 i_clk = ~i_clk;
    indirect_register_window DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_window_base(i_window_base), .i_mem_rd(i_mem_rd), .i_mem_wr(i_mem_wr),
        .i_mem_addr(i_mem_addr), .i_mem_be(i_mem_be), .i_mem_wdata(i_mem_wdata),
        .o_mem_rdata(o_mem_rdata), .o_mem_ack(o_mem_ack), .o_mem_err(o_mem_err),
        .o_int_idx(o_int_idx), .o_int_rd(o_int_rd), .o_int_wr(o_int_wr),
        .o_int_wdata(o_int_wdata), .i_int_rdata(int_rdata),
        .i_int_readable(rd_ok), .i_int_writable(wr_ok));
    ctrl_regfile_model far (.i_clk(i_clk), .i_idx(o_int_idx), .i_wr(o_int_wr),
        .i_wdata(o_int_wdata), .o_rdata(int_rdata), .o_readable(rd_ok), .o_writable(wr_ok));
    // strobes counted against the accesses the rules let through
    always @(posedge i_clk)
    begin
        if (!i_sys_rst && o_int_rd)
            rd_seen++;
        if (!i_sys_rst && o_int_wr)
            wr_seen++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] rq, output logic re);
        int n;
        @(negedge i_clk);
        i_mem_rd = !w;
        i_mem_wr = w;
        i_mem_addr = a;
        i_mem_be = be;
        i_mem_wdata = d;
        n = 0;
        // request held until the ack edge, bounded wait
        do
        begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_mem_ack !== 1'b1 && n < 6);
        `CHK("ack", 1'b1, o_mem_ack)
        rq = o_mem_rdata;
        re = o_mem_err;
        // request stands through the edge that samples the ack
        @(posedge i_clk);
        @(negedge i_clk);
        i_mem_rd = 0;
        i_mem_wr = 0;
    endtask : acc
    task automatic chk(input logic w, input logic [31:0] a, input logic [3:0] be,
                       input logic [31:0] d, input logic [31:0] eq, input logic ee);
        logic [31:0] rq;
        logic re;
        acc(w, a, be, d, rq, re);
        `CHK("rdata", eq, rq)
        `CHK("err", ee, re)
    endtask : chk
    task automatic conclude;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2000) @(posedge i_clk);
        num_errors++;
        conclude();
    end
    initial
    begin
        repeat (12) @(negedge i_clk);
        i_sys_rst = 0;
        chk(0, SEL, 4'hF, 0, 0, 0);
        chk(0, WIN, 4'hF, 0, 0, 0);
        chk(1, SEL, 4'hF, 32'hABCD_EF10, 0, 0);
        chk(0, SEL, 4'hF, 0, 32'h0000_0010, 0);
        chk(1, WIN, 4'hF, 32'h1111_2222, 0, 0);
        chk(1, SEL, 4'hF, 32'h0000_0011, 0, 0);
        chk(1, WIN, 4'hF, 32'h3333_4444, 0, 0);
        chk(0, WIN, 4'hF, 0, 32'h3333_4444, 0);
        chk(1, SEL, 4'hF, 32'h0000_0010, 0, 0);
        chk(0, WIN, 4'hF, 0, 32'h1111_2222, 0);
        acc(0, WIN, 4'hF, 0, q, e);
        chk(1, WIN, 4'hF, (q & 32'hFFFF_00FF) | 32'h0000_5A00, 0, 0);
        chk(0, WIN, 4'hF, 0, 32'h1111_5A22, 0);
        chk(1, SEL, 4'h3, 32'h0000_0002, 0, 1);
        chk(0, SEL, 4'hF, 0, 32'h0000_0010, 0);
        chk(0, WIN, 4'h1, 0, 0, 1);
        chk(1, SEL, 4'hF, 32'h0000_0001, 0, 0);
        chk(1, WIN, 4'hF, 32'h0000_0007, 0, 1);
        chk(0, WIN, 4'hF, 0, 0, 0);
        chk(1, SEL, 4'hF, 32'h0000_0003, 0, 0);
        chk(1, WIN, 4'hF, 32'h0000_0009, 0, 0);
        chk(0, WIN, 4'hF, 0, 0, 1);
        `CHK("idx", 8'h03, o_int_idx)
        // move the base page; the selector follows it
        @(negedge i_clk);
        i_window_base = 8'h37;
        chk(0, 32'hFEC0_3700, 4'hF, 0, 32'h0000_0003, 0);
        // mid-run reset clears the selector
        @(negedge i_clk);
        i_sys_rst = 1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 0;
        chk(0, 32'hFEC0_3700, 4'hF, 0, 0, 0);
        // old base page must stay silent
        @(negedge i_clk);
        i_mem_rd = 1;
        i_mem_addr = SEL;
        repeat (6)
        begin
            @(posedge i_clk);
            #1;
            `CHK("ack_on_miss", 1'b0, o_mem_ack)
        end
        @(negedge i_clk);
        i_mem_rd = 0;
        `CHK("rd_strobes", 6, rd_seen)
        `CHK("wr_strobes", 4, wr_seen)
        conclude();
    end
endmodule : indirect_register_window_tb
`default_nettype wire

// ---- regwin_pkg.sv ----
// constants for the indirect register window
package regwin_pkg;
    localparam int          ADDR_W       = 32;
    localparam int          DATA_W       = 32;
    localparam int          IDX_W        = 8;
    localparam int          BE_W         = DATA_W / 8;
    localparam logic [15:0] WIN_PAGE     = 16'hFEC0;
    localparam logic [7:0]  OFF_SELECT   = 8'h00;
    localparam logic [7:0]  OFF_WINDOW   = 8'h10;
    localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] WINDOW_RESET = 32'h0000_0000;
    localparam logic [3:0]  BE_FULL      = 4'hF;
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_ISSUE = 3'b010,
        ST_DONE  = 3'b100
    } win_state_e;
endpackage : regwin_pkg
